// [hdl/sesq_pkg.sv]
// ==========================================================
package sesq_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_SLOW  = 8'h04;
  localparam logic [7:0] ADDR_STAT  = 8'h08;
  localparam logic [7:0] ADDR_MASK  = 8'h0c;
  localparam logic [7:0] ADDR_STATE = 8'h10;
  localparam logic [7:0] ADDR_CMD   = 8'h14;

  // ==========================================================
  // control field positions and reset values
  localparam int BIT_LH_DIS     = 0;
  localparam int BIT_MON_EN     = 1;
  localparam int BIT_FMON_EN    = 2;
  localparam int BIT_DELAY_EN   = 3;
  localparam int BIT_PSEUDO_EN  = 4;
  localparam int BIT_BUS_SEL    = 5;
  localparam int BIT_MOD_SEL    = 6;
  localparam int CTRL_W         = 7;
  localparam logic [6:0] CTRL_RST = 7'h08;
  localparam int SLOW_W         = 6;
  localparam logic [5:0] SLOW_RST = 6'h00;

  // ==========================================================
  // status / mask bits and state word bits
  localparam int ST_LH_CHG  = 0;
  localparam int ST_CM_RST  = 1;
  localparam int ST_EXIT    = 2;
  localparam int STAT_W     = 3;
  localparam logic [2:0] STAT_RST = 3'h0;
  localparam int SW_LIMP    = 0;
  localparam int SW_STOPPED = 1;
  localparam int SW_XTAL    = 2;
  localparam int CMD_STOP   = 0;

  // ==========================================================
  // timing counts in prescaler ticks; the boot count is in clocks
  localparam int CNT_W = 13;
  localparam logic [12:0] LONG_CNT  = 13'h1000;
  localparam logic [12:0] SHORT_CNT = 13'h0010;
  localparam logic [1:0]  BOOT_CNT  = 2'h3;

  typedef enum logic [2:0] {S_BOOT, S_RUN, S_STOP, S_WAIT, S_LIMP} sesq_state_e;

endpackage : sesq_pkg

// [hdl/sesq_sync.sv]
`timescale 1ns/1ps
// ==========================================================
// two-flop synchroniser, one per bit
module sesq_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : sesq_sync

// [hdl/sesq_presc.sv]
`timescale 1ns/1ps
// ==========================================================
// prescaler tick: one pulse every div_i+1 clocks
module sesq_presc (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // divider setting and tick
  input  wire logic [5:0] div_i,
  output logic            tick_o
);

  logic [5:0] pcnt_q;
  wire        wrap = (pcnt_q >= div_i);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pcnt_q <= 6'h00;
      tick_o <= 1'b0;
    end
    else
    begin
      pcnt_q <= wrap ? 6'h00 : pcnt_q + 6'h01;
      tick_o <= wrap;
    end
  end

  AST_PRESC_RATE: assert property (@(posedge mclk) disable iff (sys_rst)
    (tick_o && div_i != 6'h00 && $stable(div_i)) |=> !tick_o)
    else $error("prescaler ticked on consecutive clocks with divider set");

endmodule : sesq_presc

// [hdl/sesq_top.sv]
`timescale 1ns/1ps
// ==========================================================
// stop exit clock sequencer with apb register file
module sesq_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins and clock monitor
  input  wire logic        wake_pin,
  input  wire logic        pll_supply,
  input  wire logic        clock_monitor_ok,
  // clock control outputs
  output logic             cpu_stop,
  output logic             clock_monitor_reset,
  output logic             pll_bus_clock_select,
  output logic             module_clock_select,
  output logic             limp_home_status,
  output logic             crystal_clock_run,
  output logic             irq
);

  // ==========================================================
  // state and registers
  logic [6:0]            ctrl_q;
  logic [5:0]            slow_q;
  logic [2:0]            stat_q;
  logic [2:0]            mask_q;
  logic [12:0]           cnt_q;
  logic [12:0]           target_q;
  logic [1:0]            boot_q;
  logic                  limp_q;
  logic                  limp_d;
  sesq_pkg::sesq_state_e state_q;
  sesq_pkg::sesq_state_e state_d;
  logic                  cnt_clr;
  logic                  cm_fail;
  logic                  exit_ev;
  logic [12:0]           target_d;
  logic                  tick;
  logic                  wake_s;
  logic                  pll_s;
  logic                  mon_s;

  // ==========================================================
  // pin synchronisers and prescaler
  sesq_sync #(
    .W (3)
  ) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .async_i ({wake_pin, pll_supply, clock_monitor_ok}),
    .sync_o  ({wake_s, pll_s, mon_s})
  );

  sesq_presc u_presc (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .div_i   (slow_q),
    .tick_o  (tick)
  );

  // ==========================================================
  // apb decode; answer comes one cycle into the access phase
  wire acc      = psel && penable;
  wire wr_en    = acc && pready && pwrite;
  wire hit_ctrl = (paddr == sesq_pkg::ADDR_CTRL);
  wire hit_slow = (paddr == sesq_pkg::ADDR_SLOW);
  wire hit_stat = (paddr == sesq_pkg::ADDR_STAT);
  wire hit_mask = (paddr == sesq_pkg::ADDR_MASK);
  wire hit_sw   = (paddr == sesq_pkg::ADDR_STATE);
  wire hit_cmd  = (paddr == sesq_pkg::ADDR_CMD);
  wire hit_any  = hit_ctrl | hit_slow | hit_stat | hit_mask | hit_sw | hit_cmd;
  wire stop_cmd = wr_en && hit_cmd && pwdata[sesq_pkg::CMD_STOP];
  wire [2:0] stat_clr = (wr_en && hit_stat) ? pwdata[2:0] : 3'h0;

  // state word seen by software
  wire [2:0] state_word = {crystal_clock_run, cpu_stop, limp_q};

  // read mux; the command register reads as zero
  wire [31:0] rdata =
    hit_ctrl ? {25'h0, ctrl_q} :
    hit_slow ? {26'h0, slow_q} :
    hit_stat ? {29'h0, stat_q} :
    hit_mask ? {29'h0, mask_q} :
    hit_sw   ? {29'h0, state_word} : 32'h0;

  // ==========================================================
  // effective settings; a dead pll supply forces limp-home off
  wire lh_dis  = ctrl_q[sesq_pkg::BIT_LH_DIS] | ~pll_s;
  wire mon_en  = ctrl_q[sesq_pkg::BIT_MON_EN] | ctrl_q[sesq_pkg::BIT_FMON_EN];
  wire dly_en  = ctrl_q[sesq_pkg::BIT_DELAY_EN];
  wire pseudo  = ctrl_q[sesq_pkg::BIT_PSEUDO_EN];
  wire can_stop = (state_q == sesq_pkg::S_RUN) || (state_q == sesq_pkg::S_LIMP);
  wire woke    = (state_q == sesq_pkg::S_STOP) && wake_s;
  wire cnt_hit = tick && (cnt_q == target_q - 13'h0001);
  wire boot_done = (boot_q == sesq_pkg::BOOT_CNT);
  // without limp the count only runs on crystal activity
  wire cnt_run = tick && (limp_q || mon_s);

  // ==========================================================
  // sequencer next state
  always_comb
  begin
    state_d  = state_q;
    limp_d   = limp_q;
    target_d = target_q;
    cnt_clr  = 1'b0;
    cm_fail  = 1'b0;
    exit_ev  = 1'b0;
    case (state_q)
      sesq_pkg::S_BOOT:
      begin
        if (boot_done)
        begin
          state_d = pll_s ? sesq_pkg::S_LIMP : sesq_pkg::S_RUN;
          limp_d  = pll_s;
          cnt_clr = 1'b1;
        end
      end
      sesq_pkg::S_RUN, sesq_pkg::S_LIMP:
      begin
        if (stop_cmd && lh_dis && mon_en)
        begin
          cm_fail = 1'b1;
        end
        else if (stop_cmd)
        begin
          state_d = sesq_pkg::S_STOP;
          cnt_clr = 1'b1;
        end
        else if (state_q == sesq_pkg::S_LIMP && cnt_hit)
        begin
          cnt_clr = 1'b1;
          if (mon_s)
          begin
            state_d = sesq_pkg::S_RUN;
            limp_d  = 1'b0;
          end
        end
      end
      sesq_pkg::S_STOP:
      begin
        if (woke && lh_dis)
        begin
          state_d = sesq_pkg::S_WAIT;
          cnt_clr = 1'b1;
          target_d = (pseudo && !dly_en) ? sesq_pkg::SHORT_CNT : sesq_pkg::LONG_CNT;
        end
        else if (woke && dly_en)
        begin
          state_d  = sesq_pkg::S_WAIT;
          limp_d   = 1'b1;
          cnt_clr  = 1'b1;
          target_d = sesq_pkg::LONG_CNT;
        end
        else if (woke)
        begin
          state_d  = sesq_pkg::S_LIMP;
          limp_d   = 1'b1;
          cnt_clr  = 1'b1;
          exit_ev  = 1'b1;
          target_d = sesq_pkg::LONG_CNT;
        end
      end
      sesq_pkg::S_WAIT:
      begin
        if (cnt_hit && (limp_q || mon_s))
        begin
          exit_ev = 1'b1;
          cnt_clr = 1'b1;
          if (!limp_q || mon_s)
          begin
            state_d = sesq_pkg::S_RUN;
            limp_d  = 1'b0;
          end
          else
          begin
            state_d = sesq_pkg::S_LIMP;
          end
        end
      end
      default:
      begin
        state_d = sesq_pkg::S_BOOT;
      end
    endcase
  end

  // ==========================================================
  // sticky events: set wins over a write-one clear
  // flag on limp change
  wire [2:0] stat_set = {exit_ev, cm_fail, limp_d != limp_q};
  wire [2:0] stat_d   = (stat_q & ~stat_clr) | stat_set;

  // outputs computed from next-state values so they leave flops
  // limp forces clock selects
  wire bus_sel_d = limp_d | ctrl_q[sesq_pkg::BIT_BUS_SEL];
  wire mod_sel_d = ~limp_d & ctrl_q[sesq_pkg::BIT_MOD_SEL];
  wire stop_d    = (state_d == sesq_pkg::S_STOP) || (state_d == sesq_pkg::S_WAIT);
  wire xtal_d    = (state_d == sesq_pkg::S_RUN) && !limp_d;

  // ==========================================================
  // apb bus handshake and read data
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= acc && !pready;
      prdata  <= (acc && !pready && !pwrite) ? rdata : 32'h0;
      pslverr <= acc && !pready && !hit_any;
    end
  end

  // software registers
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q <= sesq_pkg::CTRL_RST;
      slow_q <= sesq_pkg::SLOW_RST;
      mask_q <= sesq_pkg::STAT_RST;
      stat_q <= sesq_pkg::STAT_RST;
    end
    else
    begin
      if (wr_en && hit_ctrl)
      begin
        ctrl_q <= pwdata[6:0];
      end
      if (wr_en && hit_slow)
      begin
        slow_q <= pwdata[5:0];
      end
      if (wr_en && hit_mask)
      begin
        mask_q <= pwdata[2:0];
      end
      stat_q <= stat_d;
    end
  end

  // sequencer state and tick counter
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q  <= sesq_pkg::S_BOOT;
      limp_q   <= 1'b0;
      boot_q   <= 2'h0;
      cnt_q    <= 13'h0000;
      target_q <= sesq_pkg::LONG_CNT;
    end
    else
    begin
      state_q  <= state_d;
      limp_q   <= limp_d;
      target_q <= target_d;
      boot_q   <= boot_done ? boot_q : boot_q + 2'h1;
      cnt_q    <= cnt_clr ? 13'h0000 : (cnt_run ? cnt_q + 13'h0001 : cnt_q);
    end
  end

  // registered outputs
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cpu_stop             <= 1'b0;
      clock_monitor_reset  <= 1'b0;
      pll_bus_clock_select <= 1'b0;
      module_clock_select  <= 1'b0;
      limp_home_status     <= 1'b0;
      crystal_clock_run    <= 1'b0;
      irq                  <= 1'b0;
    end
    else
    begin
      cpu_stop             <= stop_d;
      clock_monitor_reset  <= cm_fail;
      pll_bus_clock_select <= bus_sel_d;
      module_clock_select  <= mod_sel_d;
      limp_home_status     <= limp_d;
      crystal_clock_run    <= xtal_d;
      irq                  <= |(stat_d & mask_q);
    end
  end

  // ==========================================================
  // checks
  AST_CM_RESET: assert property (@(posedge mclk) disable iff (sys_rst)
    (stop_cmd && can_stop && lh_dis && mon_en)
      |=> (clock_monitor_reset && !cpu_stop && stat_q[sesq_pkg::ST_CM_RST]))
    else $error("stop with monitor on did not raise monitor reset");

  AST_NO_LIMP: assert property (@(posedge mclk) disable iff (sys_rst)
    (woke && lh_dis) |=> (!limp_q && state_q == sesq_pkg::S_WAIT) [*2])
    else $error("limp clock used with limp-home disabled");

  AST_LONG_DLY: assert property (@(posedge mclk) disable iff (sys_rst)
    (woke && lh_dis && !(pseudo && !dly_en)) |=> target_q == sesq_pkg::LONG_CNT)
    else $error("long exit delay not selected");

  AST_SHORT_DLY: assert property (@(posedge mclk) disable iff (sys_rst)
    (woke && lh_dis && pseudo && !dly_en) |=> target_q == sesq_pkg::SHORT_CNT)
    else $error("short exit delay not selected");

  AST_WAIT_END: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_q == sesq_pkg::S_WAIT && $past(state_q) == sesq_pkg::S_WAIT
      && state_d != sesq_pkg::S_WAIT) |-> (tick && cnt_q == target_q - 13'h0001))
    else $error("stop wait left before full count");

  AST_BOOT_LIMP: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_q == sesq_pkg::S_BOOT && boot_done && pll_s) |=> (limp_q ##1 limp_home_status))
    else $error("limp-home not entered after reset");

  AST_LIMP_SEL: assert property (@(posedge mclk) disable iff (sys_rst)
    limp_home_status |-> (pll_bus_clock_select && !module_clock_select))
    else $error("clock selects not forced in limp-home");

  AST_FAST_EXIT: assert property (@(posedge mclk) disable iff (sys_rst)
    (woke && !lh_dis && !dly_en) |=> (state_q == sesq_pkg::S_LIMP && !cpu_stop))
    else $error("fast exit did not release stop at once");

  AST_LIMP_CHECK: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_q == sesq_pkg::S_LIMP && cnt_hit && mon_s && !stop_cmd)
      |=> (!limp_q && state_q == sesq_pkg::S_RUN))
    else $error("limp-home not left with clock present");

  AST_LH_FLAG: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(limp_q) |-> stat_q[sesq_pkg::ST_LH_CHG])
    else $error("limp change flag not set");

endmodule : sesq_top

// [testbench/sesq_osc_model.sv]
`timescale 1ns/1ps
// ==========================================================
// crystal or square-wave source as seen by the clock monitor
module sesq_osc_model #(
  parameter int START = 4
) (
  // clock
  input  wire logic mclk,
  // oscillator enable, source kind and monitor view
  input  wire logic run,
  input  wire logic square,
  output logic      clock_monitor_ok
);
  int up_q = 0;

  // start-up count; a stopped crystal reports no clock at once,
  // so the monitor never sees a stale good level after a stop
  always_ff @(posedge mclk)
  begin
    up_q <= run ? ((up_q < START) ? up_q + 1 : up_q) : 0;
  end

  // square wave good at once, crystal only after start-up
  assign clock_monitor_ok = run && (square || (up_q >= START));
endmodule : sesq_osc_model

// [testbench/testbench.sv]
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the stop exit sequencer
module testbench;
  typedef struct {
    logic [7:0] ctrl;
    logic       cmr;
    int         lo;
    int         hi;
    logic       limp;
    logic [2:0] st;
  } sesq_row_s;

  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        wake_pin = 1'b0;
  logic        pll_supply = 1'b1;
  logic        osc_run = 1'b0;
  logic        square = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        clock_monitor_ok;
  logic        cpu_stop;
  logic        clock_monitor_reset;
  logic        pll_bus_clock_select;
  logic        module_clock_select;
  logic        limp_home_status;
  logic        crystal_clock_run;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          n_errors = 0;
  int          compares = 0;
  int          n_cmr = 0;
  int          cnt;
  int          c0;

  // ctrl, monitor reset, exit window lo..hi, limp after exit, status bits
  // limp fast exit whenever delay is off and limp-home is on, from plain stop or pseudo-stop
  sesq_row_s   rows [7] = '{
    '{8'h03, 1'b1, 0, 0, 1'b0, 3'h2},
    '{8'h05, 1'b1, 0, 0, 1'b0, 3'h2},
    '{8'h19, 1'b0, 4096, 4112, 1'b0, 3'h4},
    '{8'h11, 1'b0, 16, 30, 1'b0, 3'h4},
    '{8'h01, 1'b0, 4096, 4112, 1'b0, 3'h4},
    '{8'h18, 1'b0, 4096, 4112, 1'b0, 3'h5},
    '{8'h00, 1'b0, 0, 8, 1'b1, 3'h5}
  };

  // ==========================================================
  // clock, instances, pulse counter
  always #10 mclk = ~mclk;

  sesq_top u_sesq_top (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_pin(wake_pin),
    .pll_supply(pll_supply), .clock_monitor_ok(clock_monitor_ok),
    .cpu_stop(cpu_stop), .clock_monitor_reset(clock_monitor_reset),
    .pll_bus_clock_select(pll_bus_clock_select),
    .module_clock_select(module_clock_select),
    .limp_home_status(limp_home_status),
    .crystal_clock_run(crystal_clock_run), .irq(irq)
  );

  sesq_osc_model u_sesq_osc_model (
    .mclk(mclk), .run(osc_run), .square(square),
    .clock_monitor_ok(clock_monitor_ok)
  );

  // one-cycle pulses are counted so no test can miss them
  always @(posedge mclk)
  begin
    if (clock_monitor_reset === 1'b1)
      n_cmr++;
  end

  // ==========================================================
  // tasks
  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // apb transfer; three edges pass after release so psel never toggles twice
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge mclk);
      i++;
    end
    while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1)
    begin
      n_errors++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : apb

  // bounded wait for cpu_stop (lmp=0) or limp status (lmp=1) to fall
  task automatic wait_low(input logic lmp, input int lim);
    cnt = 0;
    while ((lmp ? limp_home_status : cpu_stop) !== 1'b0 && cnt < lim)
    begin
      @(posedge mclk);
      cnt++;
    end
    if (cnt >= lim)
    begin
      n_errors++;
      test_done();
    end
  endtask : wait_low

  // stop command then wake; cnt holds cycles from wake to release
  task automatic stop_wake(input logic cmr);
    c0 = n_cmr;
    apb(1'b1, sesq_pkg::ADDR_CMD, 32'h1);
    check("monitor reset", n_cmr - c0, {31'h0, cmr});
    check("stopped", cpu_stop, {31'h0, !cmr});
    if (!cmr)
    begin
      wake_pin <= 1'b1;
      wait_low(1'b0, 9000);
      wake_pin <= 1'b0;
    end
  endtask : stop_wake

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    check("limp at boot", limp_home_status, 1'b1);
    apb(1'b0, sesq_pkg::ADDR_STATE, 32'h0);
    check("state word boot", rd, 32'h1);
    apb(1'b0, sesq_pkg::ADDR_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h8);
    apb(1'b0, sesq_pkg::ADDR_SLOW, 32'h0);
    check("slow reset", rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, sesq_pkg::ADDR_CTRL, 32'h48);
    check("bus sel forced", pll_bus_clock_select, 1'b1);
    check("mod sel forced", module_clock_select, 1'b0);
    repeat (5000) @(posedge mclk);
    check("limp no clock", limp_home_status, 1'b1);
    osc_run <= 1'b1;
    wait_low(1'b1, 9000);
    check("bus sel back", pll_bus_clock_select, 1'b0);
    check("mod sel back", module_clock_select, 1'b1);
    check("crystal run", crystal_clock_run, 1'b1);
    apb(1'b0, sesq_pkg::ADDR_STAT, 32'h0);
    check("limp flag", rd[0], 1'b1);
    check("irq masked", irq, 1'b0);
    apb(1'b1, sesq_pkg::ADDR_MASK, 32'h1);
    check("irq raised", irq, 1'b1);
    apb(1'b1, sesq_pkg::ADDR_STAT, 32'h1);
    check("irq cleared", irq, 1'b0);
    // table of exit modes with the oscillator running
    for (int r = 0; r < 7; r++)
    begin
      // delay cleared only with a square-wave source
      square <= !rows[r].ctrl[3];
      apb(1'b1, sesq_pkg::ADDR_CTRL, {24'h0, rows[r].ctrl});
      apb(1'b1, sesq_pkg::ADDR_STAT, 32'h7);
      stop_wake(rows[r].cmr);
      if (!rows[r].cmr)
      begin
        check("exit window", cnt >= rows[r].lo && cnt <= rows[r].hi, 1'b1);
        check("limp on exit", limp_home_status, rows[r].limp);
        if (rows[r].limp)
          wait_low(1'b1, 9000);
      end
      apb(1'b0, sesq_pkg::ADDR_STAT, 32'h0);
      check("status", rd[2:0], rows[r].st);
    end
    // no crystal: stays stopped, never limps; a release here would fail the still stopped check
    square <= 1'b0;
    apb(1'b1, sesq_pkg::ADDR_CTRL, 32'h19);
    osc_run <= 1'b0;
    apb(1'b1, sesq_pkg::ADDR_CMD, 32'h1);
    wake_pin <= 1'b1;
    repeat (5000) @(posedge mclk);
    check("still stopped", cpu_stop, 1'b1);
    check("no limp", limp_home_status, 1'b0);
    osc_run <= 1'b1;
    wait_low(1'b0, 9000);
    wake_pin <= 1'b0;
    check("crystal resume", crystal_clock_run, 1'b1);
    // divider of two doubles the short exit
    square <= 1'b1;
    apb(1'b1, sesq_pkg::ADDR_SLOW, 32'h1);
    apb(1'b1, sesq_pkg::ADDR_CTRL, 32'h11);
    stop_wake(1'b0);
    check("slow window", cnt >= 32 && cnt <= 46, 1'b1);
    // wake from stop by a reset while the crystal restarts
    square <= 1'b0;
    apb(1'b1, sesq_pkg::ADDR_CTRL, 32'h8);
    apb(1'b1, sesq_pkg::ADDR_CMD, 32'h1);
    check("stop before reset", cpu_stop, 1'b1);
    osc_run <= 1'b0;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b1;
    osc_run <= 1'b1;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    check("limp after reset", limp_home_status, 1'b1);
    wait_low(1'b1, 9000);
    check("crystal after reset", crystal_clock_run, 1'b1);
    // pll supply low: no limp after reset, limp-home forced off
    sys_rst <= 1'b1;
    pll_supply <= 1'b0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    check("no limp at boot", limp_home_status, 1'b0);
    apb(1'b0, sesq_pkg::ADDR_STATE, 32'h0);
    check("state word run", rd, 32'h4);
    apb(1'b1, sesq_pkg::ADDR_CTRL, 32'h28);
    check("bus sel plain", pll_bus_clock_select, 1'b1);
    check("mod sel plain", module_clock_select, 1'b0);
    stop_wake(1'b0);
    check("plain stop window", cnt >= 4096 && cnt <= 4112, 1'b1);
    check("limp kept off", limp_home_status, 1'b0);
    test_done();
  end
endmodule : testbench
